// *** hdl/tsc_engine.sv ***
`timescale 1ns/1ps
// Behaviour
// - After power-on reset, idle within 240 us; no commands accepted before then.
// - Asleep, write header and command high byte still acked; any command except wakeup 0x3517 is nacked, reads too.
// - Awake, 0x7866 starts a normal conversion, 0x609C a low-power one.
// - Conversion ends within 12.1 ms (low) or 1.5 ms (medium repeatability).
// - Each transaction starts with START to address 0x70; STOP optional.
// - Commands are 16 bits, high byte first, after a write header.
// - After a finished conversion, read header acked; two bytes then CRC.
// - Next byte only after master ACK; a NACK ends the transfer.
// - Device may stretch SCL; master must tolerate it.
// - Works at any SCL rate up to 1 MHz.
// - Pins are only pulled low, never driven high.
// - Soft reset 0x805D restarts state, reloads calibration, ready within 240 us.
// - Command 0xEFC8 acked; a following read returns 16-bit ID plus CRC.
// - Checksum is CRC-8, polynomial 0x31, over the two preceding bytes.
module tsc_engine #(
    parameter int POWER_UP_CYC   = tsc_pkg::TSC_POWER_UP_DELAY_CYC,
    parameter int SOFT_RESET_CYC = tsc_pkg::TSC_SOFT_RESET_DELAY_CYC,
    parameter int CONV_LOW_CYC   = tsc_pkg::TSC_CONV_LOW_CYC,
    parameter int CONV_MED_CYC   = tsc_pkg::TSC_CONV_MEDIUM_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        link_clk_i,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_o,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic [15:0] temp_code_i,
    output logic             conv_start_o,
    output logic             conv_lowpwr_o,
    output logic             calib_load_o,
    output logic             ready_o,
    output logic             asleep_o
);
    localparam logic [tsc_pkg::TSC_TIMER_W-1:0] TMR_PU  = tsc_pkg::TSC_TIMER_W'(POWER_UP_CYC - 1);
    localparam logic [tsc_pkg::TSC_TIMER_W-1:0] TMR_SR  = tsc_pkg::TSC_TIMER_W'(SOFT_RESET_CYC - 1);
    localparam logic [tsc_pkg::TSC_TIMER_W-1:0] TMR_LOW = tsc_pkg::TSC_TIMER_W'(CONV_LOW_CYC - 1);
    localparam logic [tsc_pkg::TSC_TIMER_W-1:0] TMR_MED = tsc_pkg::TSC_TIMER_W'(CONV_MED_CYC - 1);

    // ---------------- Core domain ----------------
    tsc_pkg::tsc_core_state_type       state_ff;
    logic [tsc_pkg::TSC_TIMER_W-1:0]   timer_ff;
    logic [15:0]                       word_ff;
    logic                              valid_ff;
    logic                              echo_tgl_ff;
    logic                              cmd_seen_ff;
    logic                              cmd_tgl_s;
    tsc_pkg::tsc_stat_type             stat_ff;

    // Link-domain command holding registers, stable while the toggle is pending
    logic                              cmd_tgl_ff;
    logic [15:0]                       cmd_code_ff;

    wire cmd_new    = cmd_tgl_s ^ cmd_seen_ff;
    wire timer_zero = (timer_ff == '0);
    wire is_sleep   = cmd_code_ff == tsc_pkg::TSC_CMD_SLEEP;
    wire is_wake    = cmd_code_ff == tsc_pkg::TSC_CMD_WAKEUP;
    wire is_meas_n  = cmd_code_ff == tsc_pkg::TSC_CMD_MEAS_NORMAL;
    wire is_meas_lp = cmd_code_ff == tsc_pkg::TSC_CMD_MEAS_LOWPWR;
    wire is_srst    = cmd_code_ff == tsc_pkg::TSC_CMD_SOFT_RESET;
    wire is_rdid    = cmd_code_ff == tsc_pkg::TSC_CMD_READ_ID;
    wire idle_cmd   = cmd_new & (state_ff == tsc_pkg::TSC_CORE_IDLE);
    wire start_conv = idle_cmd & (is_meas_n | is_meas_lp);
    wire start_srst = idle_cmd & is_srst;

    tsc_sync #(.WIDTH(1)) u_cmd_sync (
        .clk_i (clk_i),
        .rst_i (sys_rst_i),
        .d_i   (cmd_tgl_ff),
        .q_o   (cmd_tgl_s)
    );

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_ff    <= tsc_pkg::TSC_CORE_BOOT;
            timer_ff    <= TMR_PU;
            word_ff     <= 16'h0000;
            valid_ff    <= 1'b0;
            cmd_seen_ff <= 1'b0;
            echo_tgl_ff <= 1'b0;
        end else begin
            cmd_seen_ff <= cmd_tgl_s;
            if (cmd_new) begin
                echo_tgl_ff <= cmd_tgl_s;
            end
            case (state_ff)
                tsc_pkg::TSC_CORE_BOOT: begin
                    timer_ff <= timer_ff - 1'b1;
                    if (timer_zero) begin
                        state_ff <= tsc_pkg::TSC_CORE_IDLE;
                    end
                end
                tsc_pkg::TSC_CORE_SLEEP: begin
                    if (cmd_new && is_wake) begin
                        state_ff <= tsc_pkg::TSC_CORE_IDLE;
                    end
                end
                tsc_pkg::TSC_CORE_IDLE: begin
                    if (start_conv) begin
                        valid_ff <= 1'b0;
                        timer_ff <= is_meas_lp ? TMR_LOW : TMR_MED;
                        state_ff <= tsc_pkg::TSC_CORE_CONV;
                    end else if (start_srst) begin
                        valid_ff <= 1'b0;
                        word_ff  <= 16'h0000;
                        timer_ff <= TMR_SR;
                        state_ff <= tsc_pkg::TSC_CORE_BOOT;
                    end else if (idle_cmd && is_rdid) begin
                        valid_ff <= 1'b0;
                        word_ff  <= tsc_pkg::TSC_PRODUCT_ID;
                        state_ff <= tsc_pkg::TSC_CORE_PUBLISH;
                    end else if (idle_cmd && is_sleep) begin
                        state_ff <= tsc_pkg::TSC_CORE_SLEEP;
                    end
                end
                tsc_pkg::TSC_CORE_CONV: begin
                    timer_ff <= timer_ff - 1'b1;
                    if (timer_zero) begin
                        word_ff  <= temp_code_i;
                        state_ff <= tsc_pkg::TSC_CORE_PUBLISH;
                    end
                end
                tsc_pkg::TSC_CORE_PUBLISH: begin
                    valid_ff <= 1'b1;
                    state_ff <= tsc_pkg::TSC_CORE_IDLE;
                end
                default: begin
                    state_ff <= tsc_pkg::TSC_CORE_BOOT;
                    timer_ff <= TMR_PU;
                end
            endcase
        end
    end

    // Front-end controls and status, all registered
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            conv_start_o  <= 1'b0;
            conv_lowpwr_o <= 1'b0;
            calib_load_o  <= 1'b1;
            ready_o       <= 1'b0;
            asleep_o      <= 1'b0;
            stat_ff       <= '0;
        end else begin
            conv_start_o  <= start_conv;
            if (start_conv) begin
                conv_lowpwr_o <= is_meas_lp;
            end
            calib_load_o  <= start_srst;
            ready_o       <= state_ff != tsc_pkg::TSC_CORE_BOOT;
            asleep_o      <= state_ff == tsc_pkg::TSC_CORE_SLEEP;
            stat_ff.ready  <= (state_ff != tsc_pkg::TSC_CORE_BOOT) & ~start_srst;
            stat_ff.asleep <= state_ff == tsc_pkg::TSC_CORE_SLEEP;
            stat_ff.busy   <= (state_ff == tsc_pkg::TSC_CORE_CONV) | start_conv;
            stat_ff.valid  <= valid_ff;
        end
    end

    // ---------------- Link domain ----------------
    logic                        lrst;
    tsc_pkg::tsc_bus_type        pin_s;
    tsc_pkg::tsc_bus_type        pin_d_ff;
    tsc_pkg::tsc_stat_type       stat_s;
    logic                        echo_s;
    tsc_pkg::tsc_link_state_type lstate_ff;
    logic [7:0]                  sh_ff;
    logic [3:0]                  cnt_ff;
    logic [1:0]                  idx_ff;
    logic                        rw_ff;
    logic                        hi_done_ff;
    logic [7:0]                  cmd_hi_ff;
    logic [15:0]                 txw_ff;
    logic [7:0]                  crc_ff;
    logic                        mack_ff;
    logic                        low_ff;
    logic [7:0]                  crc_w;

    tsc_sync #(.WIDTH(1)) u_rst_sync (
        .clk_i (link_clk_i),
        .rst_i (1'b0),
        .d_i   (sys_rst_i),
        .q_o   (lrst)
    );

    tsc_sync #(.WIDTH(2)) u_pin_sync (
        .clk_i (link_clk_i),
        .rst_i (1'b0),
        .d_i   ({scl_i, sda_i}),
        .q_o   (pin_s)
    );

    tsc_sync #(.WIDTH(5)) u_stat_sync (
        .clk_i (link_clk_i),
        .rst_i (lrst),
        .d_i   ({stat_ff, echo_tgl_ff}),
        .q_o   ({stat_s, echo_s})
    );

    tsc_crc8 u_crc (
        .data_i (word_ff),
        .crc_o  (crc_w)
    );

    // Bus event decode on synchronised pins
    wire scl_rise  = pin_s.scl & ~pin_d_ff.scl;
    wire scl_fall  = ~pin_s.scl & pin_d_ff.scl;
    wire start_det = pin_s.scl & pin_d_ff.scl & pin_d_ff.sda & ~pin_s.sda;
    wire stop_det  = pin_s.scl & pin_d_ff.scl & ~pin_d_ff.sda & pin_s.sda;
    wire byte_done = scl_fall & (cnt_ff == tsc_pkg::TSC_BITS_PER_BYTE);

    wire [15:0] cmd_word = {cmd_hi_ff, sh_ff};
    wire addr_hit  = sh_ff[7:1] == tsc_pkg::TSC_DEV_ADDR;
    wire rd_ok     = ~stat_s.asleep & ~stat_s.busy & stat_s.valid;
    wire hdr_ok    = addr_hit & stat_s.ready & (~sh_ff[0] | rd_ok);
    wire cmd_known = (cmd_word == tsc_pkg::TSC_CMD_SLEEP) | (cmd_word == tsc_pkg::TSC_CMD_WAKEUP)
                   | (cmd_word == tsc_pkg::TSC_CMD_MEAS_NORMAL) | (cmd_word == tsc_pkg::TSC_CMD_MEAS_LOWPWR)
                   | (cmd_word == tsc_pkg::TSC_CMD_SOFT_RESET) | (cmd_word == tsc_pkg::TSC_CMD_READ_ID);
    wire cmd_ok    = stat_s.ready & (stat_s.asleep ? (cmd_word == tsc_pkg::TSC_CMD_WAKEUP)
                                                   : (cmd_known & ~stat_s.busy));
    wire [7:0] next_byte = (idx_ff == tsc_pkg::TSC_TX_IDX_MSB) ? txw_ff[7:0] : crc_ff;
    wire more_tx   = mack_ff & (idx_ff != tsc_pkg::TSC_TX_IDX_CRC);

    always_ff @(posedge link_clk_i) begin
        if (lrst) begin
            pin_d_ff <= '1;
            low_ff   <= 1'b0;
        end else begin
            pin_d_ff <= pin_s;
            low_ff   <= 1'b0;
        end
    end

    assign scl_o = low_ff;
    assign sda_o = low_ff;

    always_ff @(posedge link_clk_i) begin
        if (lrst) begin
            lstate_ff   <= tsc_pkg::TSC_LNK_IDLE;
            sh_ff       <= 8'h00;
            cnt_ff      <= 4'h0;
            idx_ff      <= 2'h0;
            rw_ff       <= 1'b0;
            hi_done_ff  <= 1'b0;
            cmd_hi_ff   <= 8'h00;
            cmd_code_ff <= 16'h0000;
            cmd_tgl_ff  <= 1'b0;
            txw_ff      <= 16'h0000;
            crc_ff      <= 8'h00;
            mack_ff     <= 1'b0;
            sda_oe_o    <= 1'b0;
            scl_oe_o    <= 1'b0;
        end else if (start_det) begin
            lstate_ff <= tsc_pkg::TSC_LNK_ADDR;
            cnt_ff    <= 4'h0;
            sda_oe_o  <= 1'b0;
        end else if (stop_det) begin
            lstate_ff <= tsc_pkg::TSC_LNK_IDLE;
            sda_oe_o  <= 1'b0;
        end else begin
            case (lstate_ff)
                tsc_pkg::TSC_LNK_IDLE: begin
                    sda_oe_o <= 1'b0;
                end
                tsc_pkg::TSC_LNK_ADDR: begin
                    if (scl_rise) begin
                        sh_ff  <= {sh_ff[6:0], pin_s.sda};
                        cnt_ff <= cnt_ff + 1'b1;
                    end else if (byte_done) begin
                        rw_ff     <= sh_ff[0];
                        sda_oe_o  <= hdr_ok;
                        lstate_ff <= hdr_ok ? tsc_pkg::TSC_LNK_ADDR_ACK : tsc_pkg::TSC_LNK_IDLE;
                    end
                end
                tsc_pkg::TSC_LNK_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_ff <= rw_ff ? tsc_pkg::TSC_FIRST_BIT_CNT : 4'h0;
                        if (rw_ff) begin
                            txw_ff    <= word_ff;
                            crc_ff    <= crc_w;
                            sh_ff     <= word_ff[15:8];
                            sda_oe_o  <= ~word_ff[15];
                            idx_ff    <= tsc_pkg::TSC_TX_IDX_MSB;
                            lstate_ff <= tsc_pkg::TSC_LNK_TX;
                        end else begin
                            sda_oe_o   <= 1'b0;
                            hi_done_ff <= 1'b0;
                            lstate_ff  <= tsc_pkg::TSC_LNK_CMD;
                        end
                    end
                end
                tsc_pkg::TSC_LNK_CMD: begin
                    if (scl_rise) begin
                        sh_ff  <= {sh_ff[6:0], pin_s.sda};
                        cnt_ff <= cnt_ff + 1'b1;
                    end else if (byte_done) begin
                        if (!hi_done_ff) begin
                            cmd_hi_ff <= sh_ff;
                            sda_oe_o  <= stat_s.ready;
                            lstate_ff <= stat_s.ready ? tsc_pkg::TSC_LNK_CMD_ACK : tsc_pkg::TSC_LNK_IDLE;
                        end else if (cmd_ok) begin
                            cmd_code_ff <= cmd_word;
                            cmd_tgl_ff  <= ~cmd_tgl_ff;
                            sda_oe_o    <= 1'b1;
                            lstate_ff   <= tsc_pkg::TSC_LNK_CMD_ACK;
                        end else begin
                            lstate_ff <= tsc_pkg::TSC_LNK_IDLE;
                        end
                    end
                end
                tsc_pkg::TSC_LNK_CMD_ACK: begin
                    if (scl_fall) begin
                        sda_oe_o <= 1'b0;
                        cnt_ff   <= 4'h0;
                        if (hi_done_ff) begin
                            scl_oe_o  <= 1'b1;
                            lstate_ff <= tsc_pkg::TSC_LNK_STRETCH;
                        end else begin
                            hi_done_ff <= 1'b1;
                            lstate_ff  <= tsc_pkg::TSC_LNK_CMD;
                        end
                    end
                end
                tsc_pkg::TSC_LNK_STRETCH: begin
                    if (echo_s == cmd_tgl_ff) begin
                        scl_oe_o  <= 1'b0;
                        lstate_ff <= tsc_pkg::TSC_LNK_IDLE;
                    end
                end
                tsc_pkg::TSC_LNK_TX: begin
                    if (byte_done) begin
                        sda_oe_o  <= 1'b0;
                        lstate_ff <= tsc_pkg::TSC_LNK_TX_ACK;
                    end else if (scl_fall) begin
                        sda_oe_o <= ~sh_ff[6];
                        sh_ff    <= {sh_ff[6:0], 1'b0};
                        cnt_ff   <= cnt_ff + 1'b1;
                    end
                end
                tsc_pkg::TSC_LNK_TX_ACK: begin
                    if (scl_rise) begin
                        mack_ff <= ~pin_s.sda;
                    end else if (scl_fall) begin
                        if (more_tx) begin
                            sh_ff     <= next_byte;
                            sda_oe_o  <= ~next_byte[7];
                            cnt_ff    <= tsc_pkg::TSC_FIRST_BIT_CNT;
                            idx_ff    <= idx_ff + 1'b1;
                            lstate_ff <= tsc_pkg::TSC_LNK_TX;
                        end else begin
                            lstate_ff <= tsc_pkg::TSC_LNK_IDLE;
                        end
                    end
                end
                default: begin
                    lstate_ff <= tsc_pkg::TSC_LNK_IDLE;
                    sda_oe_o  <= 1'b0;
                    scl_oe_o  <= 1'b0;
                end
            endcase
        end
    end
endmodule : tsc_engine

// *** hdl/tsc_pkg.sv ***
package tsc_pkg;

    // Bus target address and 16-bit command codes
    localparam logic [6:0]  TSC_DEV_ADDR        = 7'h70;
    localparam logic [15:0] TSC_CMD_SLEEP       = 16'hB098;
    localparam logic [15:0] TSC_CMD_WAKEUP      = 16'h3517;
    localparam logic [15:0] TSC_CMD_MEAS_NORMAL = 16'h7866;
    localparam logic [15:0] TSC_CMD_MEAS_LOWPWR = 16'h609C;
    localparam logic [15:0] TSC_CMD_SOFT_RESET  = 16'h805D;
    localparam logic [15:0] TSC_CMD_READ_ID     = 16'hEFC8;

    // Checksum generator
    localparam logic [7:0]  TSC_CRC_POLY        = 8'h31;
    localparam logic [7:0]  TSC_CRC_INIT        = 8'hFF;

    // Product identifier, value is arbitrary
    localparam logic [15:0] TSC_PRODUCT_ID      = 16'h5A3C;

    // Times and derived cycle counts at the core clock
    localparam int TSC_CLK_PERIOD_NS            = 8;
    localparam int TSC_POWER_UP_DELAY_US        = 240;
    localparam int TSC_SOFT_RESET_DELAY_US      = 240;
    localparam int TSC_CONV_LOW_DURATION_US     = 12100;
    localparam int TSC_CONV_MEDIUM_DURATION_US  = 1500;
    localparam int TSC_POWER_UP_DELAY_CYC       = (TSC_POWER_UP_DELAY_US * 1000) / TSC_CLK_PERIOD_NS;
    localparam int TSC_SOFT_RESET_DELAY_CYC     = (TSC_SOFT_RESET_DELAY_US * 1000) / TSC_CLK_PERIOD_NS;
    localparam int TSC_CONV_LOW_CYC             = (TSC_CONV_LOW_DURATION_US * 1000) / TSC_CLK_PERIOD_NS;
    localparam int TSC_CONV_MEDIUM_CYC          = (TSC_CONV_MEDIUM_DURATION_US * 1000) / TSC_CLK_PERIOD_NS;
    localparam int TSC_TIMER_W                  = 21;

    // Byte framing
    localparam logic [3:0]  TSC_BITS_PER_BYTE   = 4'h8;
    localparam logic [3:0]  TSC_FIRST_BIT_CNT   = 4'h1;
    localparam logic [1:0]  TSC_TX_IDX_MSB      = 2'h0;
    localparam logic [1:0]  TSC_TX_IDX_CRC      = 2'h2;

    typedef enum logic [4:0] {
        TSC_CORE_BOOT    = 5'h01,
        TSC_CORE_IDLE    = 5'h02,
        TSC_CORE_SLEEP   = 5'h04,
        TSC_CORE_CONV    = 5'h08,
        TSC_CORE_PUBLISH = 5'h10
    } tsc_core_state_type;

    typedef enum logic [7:0] {
        TSC_LNK_IDLE     = 8'h01,
        TSC_LNK_ADDR     = 8'h02,
        TSC_LNK_ADDR_ACK = 8'h04,
        TSC_LNK_CMD      = 8'h08,
        TSC_LNK_CMD_ACK  = 8'h10,
        TSC_LNK_STRETCH  = 8'h20,
        TSC_LNK_TX       = 8'h40,
        TSC_LNK_TX_ACK   = 8'h80
    } tsc_link_state_type;

    // Core status levels seen by the link side
    typedef struct packed {
        logic ready;
        logic asleep;
        logic busy;
        logic valid;
    } tsc_stat_type;

    // Sampled bus pins
    typedef struct packed {
        logic scl;
        logic sda;
    } tsc_bus_type;

endpackage : tsc_pkg

// *** hdl/tsc_sync.sv ***
`timescale 1ns/1ps
module tsc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_ff;

    // Two-stage synchroniser, first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            q_o     <= '0;
        end else begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end
endmodule : tsc_sync

// *** hdl/tsc_crc8.sv ***
`timescale 1ns/1ps
module tsc_crc8 (
    input  wire logic [15:0] data_i,
    output logic      [7:0]  crc_o
);
    logic [7:0] stage [0:16];

    assign stage[0] = tsc_pkg::TSC_CRC_INIT;

    // One shift stage per data bit, most significant bit first
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_bit
            assign stage[i+1] = {stage[i][6:0], 1'b0}
                              ^ ((stage[i][7] ^ data_i[15-i]) ? tsc_pkg::TSC_CRC_POLY : 8'h00);
        end
    endgenerate

    assign crc_o = stage[16];
endmodule : tsc_crc8

// *** bench/tsc_engine_sva.sv ***
`timescale 1ns/1ps
module tsc_chk #(
    parameter int POWER_UP_CYC   = 40,
    parameter int SOFT_RESET_CYC = 40
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic conv_start_o,
    input wire logic calib_load_o,
    input wire logic ready_o,
    input wire logic asleep_o
);
    localparam int HI = ((POWER_UP_CYC > SOFT_RESET_CYC) ? POWER_UP_CYC : SOFT_RESET_CYC) + 4;
    localparam int LO = ((POWER_UP_CYC < SOFT_RESET_CYC) ? POWER_UP_CYC : SOFT_RESET_CYC) - 4;
    // Cycles spent with ready low
    int unsigned down_ff;
    always_ff @(posedge clk_i) begin
        down_ff <= (sys_rst_i || ready_o) ? 0 : down_ff + 1;
    end
    a_scl_low_only: assert property (@(posedge link_clk_i) disable iff (sys_rst_i) !scl_o)
        else $error("scl output not low");
    a_sda_low_only: assert property (@(posedge link_clk_i) disable iff (sys_rst_i) !sda_o)
        else $error("sda output not low");
    a_boot_bounded: assert property (@(posedge clk_i) disable iff (sys_rst_i) down_ff <= HI)
        else $error("boot too long");
    a_boot_not_early: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(ready_o) |-> down_ff >= LO) else $error("boot too short");
    a_conv_when_awake: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        conv_start_o |-> ready_o && !asleep_o) else $error("conversion while asleep or booting");
    a_conv_one_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        conv_start_o |=> !conv_start_o) else $error("conversion start not a pulse");
    a_calib_one_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(calib_load_o) |=> !calib_load_o ##[0:3] !ready_o) else $error("soft reset sequence");
    a_data_scl_low: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
        $changed(sda_oe_o) |-> !scl_i) else $error("sda changed while scl high");
    a_stretch_short: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
        $rose(scl_oe_o) |-> !scl_i ##[1:40] !scl_oe_o) else $error("stretch not bounded");
endmodule : tsc_chk
bind tsc_engine tsc_chk #(.POWER_UP_CYC(POWER_UP_CYC), .SOFT_RESET_CYC(SOFT_RESET_CYC)) tsc_chk_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .conv_start_o(conv_start_o),
    .calib_load_o(calib_load_o), .ready_o(ready_o), .asleep_o(asleep_o));

// *** bench/tsc_mst.sv ***
`timescale 1ns/1ps
module tsc_mst #(
    parameter int HALF_NS = 500
) (
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      scl_oe_o,
    output logic      sda_oe_o
);
    int n_stall = 0;
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end
    // Start when s is high, stop otherwise
    task automatic cond(input logic s);
        #(HALF_NS / 4);
        sda_oe_o = ~s;
        #HALF_NS;
        scl_oe_o = 1'b0;
        #HALF_NS;
        sda_oe_o = s;
        #HALF_NS;
        scl_oe_o = s;
    endtask : cond
    task automatic bit_x(input logic b, output logic r);
        #(HALF_NS / 4);
        sda_oe_o = ~b;
        #HALF_NS;
        scl_oe_o = 1'b0;
        for (int i = 0; i < 500 && scl_i !== 1'b1; i++) #8;
        if (scl_i !== 1'b1) n_stall++;
        #HALF_NS;
        r = sda_i;
        scl_oe_o = 1'b1;
    endtask : bit_x
    task automatic xbyte(input logic [7:0] d, input logic m_ack, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(~m_ack, r);
        ack = ~r;
    endtask : xbyte
endmodule : tsc_mst

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic        clk_i       = 1'b0;
    logic        link_clk_i  = 1'b0;
    logic        sys_rst_i   = 1'b1;
    logic [15:0] temp_code_i = 16'h0000;
    logic        m_scl, m_sda, d_scl, d_sda, lowpwr, ready, asleep, cstart, calib, d_sclo, d_sdao;
    wire         scl_w       = ~(m_scl | d_scl);
    wire         sda_w       = ~(m_sda | d_sda);
    int          n_fail      = 0;
    int          n_compared  = 0;
    int          n_drop      = 0;
    int          n_conv      = 0, n_cal = 0, n_hi = 0;
    tsc_engine #(.POWER_UP_CYC(40), .SOFT_RESET_CYC(40), .CONV_LOW_CYC(200), .CONV_MED_CYC(100)) tsc_engine_inst (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i), .scl_i(scl_w), .scl_o(d_sclo),
        .scl_oe_o(d_scl), .sda_i(sda_w), .sda_o(d_sdao), .sda_oe_o(d_sda), .temp_code_i(temp_code_i),
        .conv_start_o(cstart), .conv_lowpwr_o(lowpwr), .calib_load_o(calib), .ready_o(ready), .asleep_o(asleep));
    tsc_mst tsc_mst_inst (.scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(m_scl), .sda_oe_o(m_sda));
    always @(negedge ready) n_drop++;
    always @(negedge clk_i) if (!sys_rst_i) begin
        n_conv += (cstart === 1'b1);
        n_cal  += (calib === 1'b1);
        n_hi   += (d_sclo !== 1'b0 || d_sdao !== 1'b0);
    end
    initial forever #4 clk_i = ~clk_i;
    initial begin
        #13;
        forever #24 link_clk_i = ~link_clk_i;
    end
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
        return c;
    endfunction : crc8
    // One transaction: header, then two command bytes or n read bytes
    task automatic xact(input logic [7:0] hdr, input logic [15:0] c, input int n,
                        output logic [2:0] a, output logic [23:0] d);
        logic [7:0] q;
        logic       k;
        a = 3'h0;
        d = 24'h000000;
        tsc_mst_inst.cond(1'b1);
        tsc_mst_inst.xbyte(hdr, 1'b0, q, a[2]);
        for (int i = 0; i < n && a[2] === 1'b1; i++) begin
            tsc_mst_inst.xbyte(hdr[0] ? 8'hFF : c[15 - 8 * i -: 8], hdr[0] && i < n - 1, q, k);
            d[23 - 8 * i -: 8] = q;
            if (!hdr[0]) a[1 - i] = k;
        end
        tsc_mst_inst.cond(1'b0);
    endtask : xact
    task automatic sc_meas(input logic [15:0] c, input logic [15:0] t, input logic [15:0] w,
                           input logic lp, input int n);
        logic [2:0]  a;
        logic [23:0] d;
        int          cs;
        @(negedge clk_i);
        cs = n_conv;
        temp_code_i = t;
        xact(8'hE0, c, 2, a, d);
        chk("cmd ack", 24'h000007, 24'(a));
        chk("low power", 24'(lp), 24'(lowpwr));
        chk("conv start", 24'(c != 16'hEFC8), 24'(n_conv - cs));
        xact(8'hE1, c, n, a, d);
        chk("read ack", 24'h000004, 24'(a));
        chk("data", {w, crc8(w)} >> (24 - 8 * n), d >> (24 - 8 * n));
    endtask : sc_meas
    task automatic sc_sleep();
        logic [2:0]  a;
        logic [23:0] d;
        xact(8'hE0, 16'hB098, 2, a, d);
        chk("sleep ack", 24'h000007, 24'(a));
        chk("asleep", 24'h000001, 24'(asleep));
        xact(8'hE0, 16'h7866, 2, a, d);
        chk("asleep cmd", 24'h000006, 24'(a));
        xact(8'hE1, 16'h0000, 3, a, d);
        chk("asleep read", 24'h000000, 24'(a));
        xact(8'hE0, 16'h3517, 2, a, d);
        chk("wake ack", 24'h000007, 24'(a));
        chk("awake", 24'h000000, 24'(asleep));
    endtask : sc_sleep
    task automatic sc_reset();
        logic [2:0]  a;
        logic [23:0] d;
        int          drops;
        int          cals;
        drops = n_drop;
        cals = n_cal;
        xact(8'hE2, 16'h0000, 2, a, d);
        chk("other addr", 24'h000000, 24'(a));
        xact(8'hE0, 16'h805D, 2, a, d);
        chk("reset ack", 24'h000007, 24'(a));
        chk("ready drops", 24'(drops + 1), 24'(n_drop));
        chk("calib pulse", 24'h000001, 24'(n_cal - cals));
        chk("ready back", 24'h000001, 24'(ready));
        xact(8'hE1, 16'h0000, 3, a, d);
        chk("read after reset", 24'h000000, 24'(a));
    endtask : sc_reset
    initial begin
        repeat (6) @(negedge link_clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        for (int i = 0; i < 100 && ready !== 1'b1; i++) @(negedge clk_i);
        chk("ready", 24'h000001, 24'(ready));
        if (ready !== 1'b1) finish_test();
        repeat (10) @(negedge link_clk_i);
        sc_meas(16'h7866, 16'hBEEF, 16'hBEEF, 1'b0, 3);
        sc_meas(16'h609C, 16'h1234, 16'h1234, 1'b1, 1);
        sc_meas(16'hEFC8, 16'h0000, tsc_pkg::TSC_PRODUCT_ID, 1'b1, 3);
        sc_sleep();
        sc_reset();
        chk("stretch wait", 24'h000000, 24'(tsc_mst_inst.n_stall));
        chk("pin data low", 24'h000000, 24'(n_hi));
        finish_test();
    end
    initial begin
        #600000;
        n_fail++;
        finish_test();
    end
endmodule : testbench
